// file: src/sar_seq_pkg.sv
package sar_seq_pkg;

    localparam int NUM_CH = 18;
    localparam int NUM_EXT = 12;
    localparam int CH_W = 5;
    localparam int RES_W = 12;
    localparam int CONV_CYCLES = 19;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_CHEN = 8'h0c;
    localparam logic [7:0] OFF_CMP = 8'h10;
    localparam logic [7:0] OFF_CAL = 8'h14;
    localparam logic [7:0] OFF_SMP_SHARED = 8'h18;
    localparam logic [7:0] OFF_SMP_BASE = 8'h40;
    localparam logic [7:0] OFF_DATA_BASE = 8'h80;

    // control field positions
    localparam int CTRL_START = 0;
    localparam int CTRL_MODE_LO = 1;
    localparam int CTRL_RES_LO = 3;
    localparam int CTRL_CH_LO = 5;
    localparam int CTRL_TRG_EXT = 10;
    localparam int CTRL_TRG_TMR = 11;
    localparam int CTRL_TSEL_LO = 12;
    localparam int CTRL_PWR_LO = 14;
    localparam int CTRL_CAL_RUN = 16;
    localparam int CTRL_DMA_EN = 17;

    // status bits
    localparam int ST_DONE = 0;
    localparam int ST_CMP = 1;
    localparam int ST_CAL = 2;
    localparam int ST_W = 3;

    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [7:0] SMP_RST = 8'h01;
    localparam int CAL_CYCLES = 32;

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_SCAN = 2'h1,
        MODE_CONT = 2'h2
    } conv_mode_t;

    typedef enum logic [1:0] {
        RES_12 = 2'h0,
        RES_10 = 2'h1,
        RES_8 = 2'h2,
        RES_6 = 2'h3
    } res_sel_t;

    typedef enum logic [1:0] {
        PWR_ON = 2'h0,
        PWR_STANDBY = 2'h1,
        PWR_DOWN = 2'h2
    } pwr_sel_t;

    typedef struct packed {
        logic [CH_W-1:0] ch;
        logic sample;
        logic convert;
        logic [1:0] res;
        logic [1:0] pwr;
        logic cal_run;
        logic cal_load;
        logic [RES_W-1:0] cal_word;
    } analog_ctl_t;

endpackage

// file: src/sar_adc_sequencer.sv
// Behaviour
// - three modes exist: single, single-cycle scan, continuous scan.
// - single mode converts the selected channel once then stops.
// - scan converts each enabled channel once, lowest to highest.
// - continuous scan repeats scans until software clears start.
// - start by writing one to start bit or by external pin.
// - one of four timer events may start; timer runs request transfer.
// - resolution selectable as 12, 10, 8 or 6 bits.
// - channels 0-11 own sampling times; 12-17 share one.
// - selector covers external channels 0-11 and internal 12-17.
// - conversion lasts 19 cycles plus channel sampling time.
// - each result lands in that channel's own data register.
// - result equal to compare value raises interrupt if enabled.
// - power-down and standby states selectable by software.
// - calibration run and calibration word load supported.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module sar_adc_sequencer (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // triggers
    input wire logic i_external_trigger_pin,
    input wire logic i_timer0_event,
    input wire logic i_timer1_event,
    input wire logic i_timer2_event,
    input wire logic i_timer3_event,
    // analog core
    input wire logic i_cmp_bit,
    input wire logic [sar_seq_pkg::RES_W-1:0] i_cal_word,
    output sar_seq_pkg::analog_ctl_t o_analog,
    output logic [sar_seq_pkg::RES_W-1:0] o_trial,
    // system
    output logic o_irq,
    output logic o_busy,
    output logic o_peripheral_transfer_channel_req
);

    localparam int NCH = sar_seq_pkg::NUM_CH;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT,
        ST_NEXT,
        ST_CAL
    } seq_state_t;

    function automatic logic [4:0] first_en(input logic [NCH-1:0] en,
                                            input logic [4:0] from);
        logic [4:0] r;
        r = 5'h1f;
        for (int i = NCH - 1; i >= 0; i--)
        begin
            if (en[i] && 5'(i) >= from)
            begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [3:0] res_bits(input logic [1:0] sel);
        logic [3:0] r;
        unique case (sel)
            2'h0: r = 4'hc;
            2'h1: r = 4'ha;
            2'h2: r = 4'h8;
            default: r = 4'h6;
        endcase
        return r;
    endfunction

    // bus address phase capture
    logic wr_pend_ff, nxt_wr_pend;
    logic [7:0] addr_ff, nxt_addr;
    logic [31:0] ctrl_ff, nxt_ctrl;
    logic [sar_seq_pkg::ST_W-1:0] stat_ff, nxt_stat;
    logic [sar_seq_pkg::ST_W-1:0] mask_ff, nxt_mask;
    logic [NCH-1:0] chen_ff, nxt_chen;
    logic [11:0] cmpv_ff, nxt_cmpv;
    logic [11:0] calw_ff, nxt_calw;
    logic [7:0] smp_ff [0:NCH-1];
    logic [7:0] nxt_smp [0:NCH-1];
    logic [11:0] data_ff [0:NCH-1];
    logic [11:0] nxt_data [0:NCH-1];
    logic [31:0] rdata_ff, nxt_rdata;
    logic irq_ff, nxt_irq;
    logic dma_ff, nxt_dma;

    seq_state_t st_ff, nxt_st;
    logic [4:0] ch_ff, nxt_ch;
    logic [7:0] cnt_ff, nxt_cnt;
    logic [11:0] sar_ff, nxt_sar;
    logic [3:0] bit_ff, nxt_bit;
    logic tmr_run_ff, nxt_tmr_run;
    logic ext_d_ff, tmr_d_ff;

    logic bus_req;
    logic [7:0] wr_a;
    logic [4:0] idx;
    logic tmr_sel;
    logic trig;
    logic [1:0] mode;
    logic [7:0] smp_now;
    logic [4:0] first_ch, next_ch;
    logic set_done, set_cmp, set_cal;
    logic [11:0] result;

    assign bus_req = i_hsel && i_hready && i_htrans[1];
    assign wr_a = addr_ff;
    assign mode = ctrl_ff[sar_seq_pkg::CTRL_MODE_LO +: 2];
    always_comb
    begin
        unique case (ctrl_ff[sar_seq_pkg::CTRL_TSEL_LO +: 2])
            2'h0: tmr_sel = i_timer0_event;
            2'h1: tmr_sel = i_timer1_event;
            2'h2: tmr_sel = i_timer2_event;
            default: tmr_sel = i_timer3_event;
        endcase
    end
    assign smp_now = (ch_ff < 5'(sar_seq_pkg::NUM_EXT)) ? smp_ff[ch_ff]
                                                      : smp_ff[NCH-1];
    assign first_ch = first_en(chen_ff, 5'h0);
    assign next_ch = first_en(chen_ff, ch_ff + 5'h1);

    // rising-edge triggers, only seen while idle
    assign trig = (st_ff == ST_IDLE)
        && ctrl_ff[sar_seq_pkg::CTRL_PWR_LO +: 2] == 2'(sar_seq_pkg::PWR_ON)
        && ((ctrl_ff[sar_seq_pkg::CTRL_TRG_EXT]
             && i_external_trigger_pin && !ext_d_ff)
         || (ctrl_ff[sar_seq_pkg::CTRL_TRG_TMR]
             && tmr_sel && !tmr_d_ff));

    always_comb
    begin
        nxt_st = st_ff;
        nxt_ch = ch_ff;
        nxt_cnt = cnt_ff;
        nxt_sar = sar_ff;
        nxt_bit = bit_ff;
        nxt_tmr_run = tmr_run_ff;
        nxt_dma = 1'b0;
        set_done = 1'b0;
        set_cmp = 1'b0;
        set_cal = 1'b0;
        result = sar_ff;
        for (int i = 0; i < NCH; i++)
        begin
            nxt_data[i] = data_ff[i];
        end
        unique case (st_ff)
            ST_IDLE:
            begin
                if (ctrl_ff[sar_seq_pkg::CTRL_CAL_RUN])
                begin
                    nxt_st = ST_CAL;
                    nxt_cnt = 8'(sar_seq_pkg::CAL_CYCLES);
                end
                // start bit stays set until the run ends, so idle sees it
                else if (trig || (ctrl_ff[sar_seq_pkg::CTRL_START]
                        && !tmr_run_ff))
                begin
                    nxt_ch = (mode == 2'(sar_seq_pkg::MODE_SINGLE))
                        ? ctrl_ff[sar_seq_pkg::CTRL_CH_LO +: 5] : first_ch;
                    nxt_tmr_run = trig && ctrl_ff[sar_seq_pkg::CTRL_TRG_TMR];
                    if (nxt_ch < 5'(NCH))
                    begin
                        nxt_st = ST_SAMPLE;
                        nxt_cnt = 8'h0;
                    end
                end
            end
            ST_SAMPLE:
            begin
                nxt_cnt = cnt_ff + 8'h1;
                if (cnt_ff + 8'h1 >= smp_now)
                begin
                    nxt_st = ST_CONVERT;
                    nxt_cnt = 8'h0;
                    nxt_sar = 12'h800;
                    nxt_bit = 4'hb;
                end
            end
            ST_CONVERT:
            begin
                // 19 cycles: 12 trial bits, then settle time
                nxt_cnt = cnt_ff + 8'h1;
                if (cnt_ff < 8'hc)
                begin
                    nxt_sar[bit_ff] = i_cmp_bit;
                    if (bit_ff != 4'h0)
                    begin
                        nxt_sar[bit_ff - 4'h1] = 1'b1;
                        nxt_bit = bit_ff - 4'h1;
                    end
                end
                if (cnt_ff == 8'(sar_seq_pkg::CONV_CYCLES - 1))
                begin
                    nxt_st = ST_NEXT;
                end
            end
            ST_NEXT:
            begin
                result = sar_ff & ~(12'hfff >> res_bits(
                    ctrl_ff[sar_seq_pkg::CTRL_RES_LO +: 2]));
                nxt_data[ch_ff] = result;
                set_cmp = (result == cmpv_ff);
                nxt_dma = tmr_run_ff && ctrl_ff[sar_seq_pkg::CTRL_DMA_EN];
                nxt_st = ST_IDLE;
                if (mode == 2'(sar_seq_pkg::MODE_SINGLE))
                begin
                    set_done = 1'b1;
                end
                else if (next_ch < 5'(NCH))
                begin
                    nxt_ch = next_ch;
                    nxt_st = ST_SAMPLE;
                    nxt_cnt = 8'h0;
                end
                else
                begin
                    set_done = 1'b1;
                    if (mode == 2'(sar_seq_pkg::MODE_CONT)
                        && ctrl_ff[sar_seq_pkg::CTRL_START])
                    begin
                        nxt_ch = first_ch;
                        nxt_st = ST_SAMPLE;
                        nxt_cnt = 8'h0;
                    end
                end
                if (nxt_st == ST_IDLE)
                begin
                    nxt_tmr_run = 1'b0;
                end
            end
            ST_CAL:
            begin
                nxt_cnt = cnt_ff - 8'h1;
                if (cnt_ff == 8'h1)
                begin
                    nxt_st = ST_IDLE;
                    set_cal = 1'b1;
                end
            end
            default: nxt_st = ST_IDLE;
        endcase
    end

    // register file
    always_comb
    begin
        nxt_wr_pend = bus_req && i_hwrite;
        nxt_addr = bus_req ? i_haddr[7:0] : addr_ff;
        nxt_ctrl = ctrl_ff;
        nxt_mask = mask_ff;
        nxt_chen = chen_ff;
        nxt_cmpv = cmpv_ff;
        nxt_calw = calw_ff;
        nxt_stat = stat_ff;
        nxt_rdata = 32'h0;
        idx = {1'b0, wr_a[5:2]};
        for (int i = 0; i < NCH; i++)
        begin
            nxt_smp[i] = smp_ff[i];
        end
        if (wr_pend_ff)
        begin
            unique case (wr_a)
                sar_seq_pkg::OFF_CTRL: nxt_ctrl = i_hwdata;
                sar_seq_pkg::OFF_STATUS:
                    nxt_stat = stat_ff & ~i_hwdata[sar_seq_pkg::ST_W-1:0];
                sar_seq_pkg::OFF_MASK:
                    nxt_mask = i_hwdata[sar_seq_pkg::ST_W-1:0];
                sar_seq_pkg::OFF_CHEN: nxt_chen = i_hwdata[NCH-1:0];
                sar_seq_pkg::OFF_CMP: nxt_cmpv = i_hwdata[11:0];
                sar_seq_pkg::OFF_CAL: nxt_calw = i_hwdata[11:0];
                sar_seq_pkg::OFF_SMP_SHARED:
                begin
                    for (int i = sar_seq_pkg::NUM_EXT; i < NCH; i++)
                    begin
                        nxt_smp[i] = i_hwdata[7:0];
                    end
                end
                default:
                begin
                    if (wr_a[7:6] == 2'h1 && idx < 5'(sar_seq_pkg::NUM_EXT))
                    begin
                        nxt_smp[idx] = i_hwdata[7:0];
                    end
                end
            endcase
        end
        // calibration run bit self-clears once sequence starts
        if (st_ff == ST_CAL)
        begin
            nxt_ctrl[sar_seq_pkg::CTRL_CAL_RUN] = 1'b0;
        end
        // single and scan drop start bit when finished
        if (set_done && nxt_st == ST_IDLE)
        begin
            nxt_ctrl[sar_seq_pkg::CTRL_START] = 1'b0;
        end
        // set wins over clear
        nxt_stat[sar_seq_pkg::ST_DONE] = nxt_stat[sar_seq_pkg::ST_DONE]
            | set_done;
        nxt_stat[sar_seq_pkg::ST_CMP] = nxt_stat[sar_seq_pkg::ST_CMP]
            | set_cmp;
        nxt_stat[sar_seq_pkg::ST_CAL] = nxt_stat[sar_seq_pkg::ST_CAL]
            | set_cal;
        if (bus_req && !i_hwrite)
        begin
            unique case (i_haddr[7:0])
                sar_seq_pkg::OFF_CTRL: nxt_rdata = ctrl_ff;
                sar_seq_pkg::OFF_STATUS:
                    nxt_rdata = {29'h0, stat_ff} | {28'h0, o_busy, 3'h0};
                sar_seq_pkg::OFF_MASK: nxt_rdata = {29'h0, mask_ff};
                sar_seq_pkg::OFF_CHEN: nxt_rdata = {14'h0, chen_ff};
                sar_seq_pkg::OFF_CMP: nxt_rdata = {20'h0, cmpv_ff};
                sar_seq_pkg::OFF_CAL: nxt_rdata = {20'h0, i_cal_word};
                sar_seq_pkg::OFF_SMP_SHARED:
                    nxt_rdata = {24'h0, smp_ff[NCH-1]};
                default:
                begin
                    if (i_haddr[7:6] == 2'h1
                        && i_haddr[5:2] < 4'(sar_seq_pkg::NUM_EXT))
                    begin
                        nxt_rdata = {24'h0, smp_ff[i_haddr[5:2]]};
                    end
                    // data words run past 0xbf, so only bit 7 selects
                    else if (i_haddr[7]
                        && i_haddr[6:2] < 5'(NCH))
                    begin
                        nxt_rdata = {20'h0, data_ff[i_haddr[6:2]]};
                    end
                end
            endcase
        end
        nxt_irq = |(nxt_stat & mask_ff);
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
        begin
            wr_pend_ff <= 1'b0;
            addr_ff <= 8'h0;
            ctrl_ff <= sar_seq_pkg::CTRL_RST;
            stat_ff <= '0;
            mask_ff <= '0;
            chen_ff <= '0;
            cmpv_ff <= 12'h0;
            calw_ff <= 12'h0;
            rdata_ff <= 32'h0;
            irq_ff <= 1'b0;
            dma_ff <= 1'b0;
            st_ff <= ST_IDLE;
            ch_ff <= 5'h0;
            cnt_ff <= 8'h0;
            sar_ff <= 12'h0;
            bit_ff <= 4'h0;
            tmr_run_ff <= 1'b0;
            ext_d_ff <= 1'b0;
            tmr_d_ff <= 1'b0;
            for (int i = 0; i < NCH; i++)
            begin
                smp_ff[i] <= sar_seq_pkg::SMP_RST;
                data_ff[i] <= 12'h0;
            end
        end
        else
        begin
            wr_pend_ff <= nxt_wr_pend;
            addr_ff <= nxt_addr;
            ctrl_ff <= nxt_ctrl;
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
            chen_ff <= nxt_chen;
            cmpv_ff <= nxt_cmpv;
            calw_ff <= nxt_calw;
            rdata_ff <= nxt_rdata;
            irq_ff <= nxt_irq;
            dma_ff <= nxt_dma;
            st_ff <= nxt_st;
            ch_ff <= nxt_ch;
            cnt_ff <= nxt_cnt;
            sar_ff <= nxt_sar;
            bit_ff <= nxt_bit;
            tmr_run_ff <= nxt_tmr_run;
            ext_d_ff <= i_external_trigger_pin;
            tmr_d_ff <= tmr_sel;
            for (int i = 0; i < NCH; i++)
            begin
                smp_ff[i] <= nxt_smp[i];
                data_ff[i] <= nxt_data[i];
            end
        end
    end

    // analog outputs registered
    sar_seq_pkg::analog_ctl_t ana_ff, nxt_ana;
    logic busy_ff;
    always_comb
    begin
        nxt_ana.ch = nxt_ch;
        nxt_ana.sample = (nxt_st == ST_SAMPLE);
        nxt_ana.convert = (nxt_st == ST_CONVERT);
        nxt_ana.res = nxt_ctrl[sar_seq_pkg::CTRL_RES_LO +: 2];
        nxt_ana.pwr = nxt_ctrl[sar_seq_pkg::CTRL_PWR_LO +: 2];
        nxt_ana.cal_run = (nxt_st == ST_CAL);
        nxt_ana.cal_load = wr_pend_ff && wr_a == sar_seq_pkg::OFF_CAL;
        nxt_ana.cal_word = nxt_calw;
    end
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
        begin
            ana_ff <= '0;
            busy_ff <= 1'b0;
        end
        else
        begin
            ana_ff <= nxt_ana;
            busy_ff <= (nxt_st != ST_IDLE);
        end
    end

    assign o_analog = ana_ff;
    assign o_trial = sar_ff;
    assign o_busy = busy_ff;
    assign o_irq = irq_ff;
    assign o_peripheral_transfer_channel_req = dma_ff;
    assign o_hrdata = rdata_ff;
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;

    // conversion phase lasts exactly 19 cycles
    property p_conv_len;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (st_ff == ST_SAMPLE && nxt_st == ST_CONVERT) |=>
            (st_ff == ST_CONVERT) ##19 (st_ff == ST_NEXT);
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion length wrong");

    property p_done_flag;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        set_done |=> stat_ff[sar_seq_pkg::ST_DONE];
    endproperty
    a_done_flag: assert property (p_done_flag)
        else $error("done flag not set");

    property p_cmp_flag;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (st_ff == ST_NEXT && result == cmpv_ff)
            |=> stat_ff[sar_seq_pkg::ST_CMP];
    endproperty
    a_cmp_flag: assert property (p_cmp_flag)
        else $error("compare flag missing");

    property p_store;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        st_ff == ST_NEXT |=> data_ff[$past(ch_ff)] == $past(result);
    endproperty
    a_store: assert property (p_store)
        else $error("result not stored");

    property p_ascend;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (st_ff == ST_NEXT && nxt_st == ST_SAMPLE
            && mode == 2'(sar_seq_pkg::MODE_SCAN)) |=> ch_ff > $past(ch_ff);
    endproperty
    a_ascend: assert property (p_ascend)
        else $error("scan order not ascending");

    property p_single_stop;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (st_ff == ST_NEXT && mode == 2'(sar_seq_pkg::MODE_SINGLE))
            |=> st_ff == ST_IDLE;
    endproperty
    a_single_stop: assert property (p_single_stop)
        else $error("single mode did not stop");

    property p_ignore;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (st_ff == ST_SAMPLE) |=> (st_ff != ST_IDLE);
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("sampling aborted");

    property p_irq;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        ##1 (o_irq == |($past(nxt_stat) & $past(mask_ff)));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt level wrong");

endmodule

// file: verification/analog_core_model.sv
`timescale 1ns/100ps
module analog_core_model #(
    parameter logic [11:0] CAL_VAL = 12'h5a3
) (
    // control from the sequencer
    input wire sar_seq_pkg::analog_ctl_t i_analog,
    input wire logic [11:0] i_trial,
    // input levels, twelve bits per channel
    input wire logic [215:0] i_levels,
    // comparator and calibration
    output logic o_cmp_bit,
    output logic [11:0] o_cal_word
);
    logic [11:0] lvl;
    // bad channel follows the inverse trial, never a stale match
    assign lvl = (i_analog.ch < 5'h12) ? i_levels[i_analog.ch*12 +: 12] :
        ~i_trial;
    assign o_cmp_bit = (lvl >= i_trial);
    assign o_cal_word = CAL_VAL;
endmodule

// file: verification/sar_adc_sequencer_tb.sv
`timescale 1ns/100ps
module sar_adc_sequencer_tb;
    localparam logic [11:0] CAL_VAL = 12'h5a3;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic ext = 1'b0;
    logic [3:0] tmr = '0;
    logic [215:0] lvls = '0;
    logic [31:0] hrdata;
    logic hrdy;
    logic hresp;
    logic cmp_bit;
    logic [11:0] cal_word;
    logic [11:0] trial;
    sar_seq_pkg::analog_ctl_t ana;
    logic irq;
    logic busy;
    logic dreq;
    logic rd_chk = 1'b0;
    logic smp_d = 1'b0;
    logic [31:0] rdata;
    logic [31:0] exp_q[$];
    logic [4:0] ch_q[$];
    int scan_ch[4] = '{2, 9, 12, 17};
    int n_fail = 0;
    int cmp_count = 0;
    int dreq_n = 0;
    int d0;
    int seed;

    sar_adc_sequencer i_dut (
        .i_ref_clk(clk), .i_rstn(rstn), .i_hsel(1'b1), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
        .o_hreadyout(hrdy), .o_hresp(hresp), .i_external_trigger_pin(ext),
        .i_timer0_event(tmr[0]), .i_timer1_event(tmr[1]),
        .i_timer2_event(tmr[2]), .i_timer3_event(tmr[3]),
        .i_cmp_bit(cmp_bit), .i_cal_word(cal_word), .o_analog(ana),
        .o_trial(trial), .o_irq(irq), .o_busy(busy),
        .o_peripheral_transfer_channel_req(dreq));

    analog_core_model #(.CAL_VAL(CAL_VAL)) i_ana (
        .i_analog(ana), .i_trial(trial), .i_levels(lvls),
        .o_cmp_bit(cmp_bit), .o_cal_word(cal_word));

    always #12.5 clk = ~clk;

    task automatic chk32(input string nm, input logic [31:0] e,
        input logic [31:0] s);
        cmp_count++;
        if (s !== e)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic tmo(input string nm);
        n_fail++;
        $display("[ERR] %s expected response seen timeout", nm);
        finish_test();
    endtask

    // results are checked here, in order of the notes queued
    always @(posedge clk)
    begin
        smp_d <= ana.sample;
        dreq_n <= dreq_n + int'(dreq);
        if (ana.sample && !smp_d)
            ch_q.push_back(ana.ch);
        if (rd_chk)
            chk32("hrdata", exp_q.pop_front(), hrdata);
    end

    task automatic rdy;
        int n;
        n = 0;
        @(posedge clk);
        while (hrdy !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk);
        end
        if (n >= 20)
            tmo("hready");
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic c, input logic [31:0] e);
        @(posedge clk);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        rdy();
        htrans <= 2'h0;
        hwdata <= d;
        if (c)
            exp_q.push_back(e);
        rd_chk <= c;
        rdy();
        rdata = hrdata;
        rd_chk <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 1'b0, '0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, '0, 1'b1, e);
    endtask

    function automatic logic [31:0] lv(input int c, input int r);
        return {20'h0, lvls[c*12 +: 12] & (12'hfff << (2 * r))};
    endfunction

    task automatic rd_ch(input int c, input int r);
        rd(8'(8'h80 + 4 * c), lv(c, r));
    endtask

    // polls without clearing so flags can still be read afterwards
    task automatic wait_done;
        int n;
        n = 0;
        rdata = '0;
        while (rdata[0] !== 1'b1)
        begin
            if (n++ > 300)
                tmo("done");
            bus(1'b0, 8'h04, '0, 1'b0, '0);
        end
    endtask

    task automatic pulse(input int t);
        repeat (4) @(posedge clk);
        if (t < 4)
            tmr[t] <= 1'b1;
        else
            ext <= 1'b1;
        repeat (3) @(posedge clk);
        tmr <= '0;
        ext <= 1'b0;
    endtask

    initial
    begin
        seed = 63;
        for (int i = 0; i < 18; i++)
            lvls[i*12 +: 12] = 12'($random(seed));
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h40, {24'h0, sar_seq_pkg::SMP_RST});
        rd(8'hfc, 32'h0);
        chk32("hresp", 32'h0, {31'h0, hresp});
        for (int r = 0; r < 4; r++)
        begin
            wr(8'h00, 32'h1 | (r << 3) | (7 << 5));
            wait_done();
            rd(8'h00, (r << 3) | (7 << 5));
            wr(8'h04, 32'h7);
            rd_ch(7, r);
        end
        wr(8'h0c, 32'h2_1204);
        ch_q.delete();
        wr(8'h00, 32'h403);
        pulse(4);
        wait_done();
        wr(8'h04, 32'h7);
        repeat (5) @(posedge clk);
        chk32("busy", 32'h0, {31'h0, busy});
        chk32("count", 32'h4, 32'(ch_q.size()));
        foreach (scan_ch[i])
        begin
            chk32("channel", 32'(scan_ch[i]), 32'(ch_q[i]));
            rd_ch(scan_ch[i], 0);
        end
        wr(8'h00, 32'h400 | (4 << 5));
        pulse(4);
        wait_done();
        wr(8'h04, 32'h7);
        rd_ch(4, 0);
        for (int t = 0; t < 4; t++)
        begin
            d0 = dreq_n;
            wr(8'h00, 32'h2_0800 | (t << 12) | (t << 5));
            pulse(t);
            wait_done();
            wr(8'h04, 32'h7);
            chk32("dma", 32'h1, 32'(dreq_n - d0));
            rd_ch(t, 0);
        end
        wr(8'h10, lv(5, 0));
        wr(8'h08, 32'h2);
        wr(8'h00, 32'h1 | (5 << 5));
        wait_done();
        rd(8'h04, 32'h3);
        chk32("irq", 32'h1, {31'h0, irq});
        wr(8'h04, 32'h2);
        rd(8'h04, 32'h1);
        chk32("irq", 32'h0, {31'h0, irq});
        wr(8'h04, 32'h1);
        wr(8'h0c, 32'h1);
        wr(8'h00, 32'h5);
        repeat (100) @(posedge clk);
        chk32("busy", 32'h1, {31'h0, busy});
        wr(8'h00, 32'h4);
        d0 = 0;
        while (busy !== 1'b0)
        begin
            if (d0++ > 300)
                tmo("busy");
            @(posedge clk);
        end
        rd_ch(0, 0);
        wr(8'h04, 32'h7);
        for (int p = 1; p < 3; p++)
        begin
            wr(8'h00, p << 14);
            repeat (2) @(posedge clk);
            chk32("pwr", 32'(p), {30'h0, ana.pwr});
        end
        wr(8'h14, 32'h3c5);
        repeat (2) @(posedge clk);
        chk32("calword", 32'h3c5, {20'h0, ana.cal_word});
        rd(8'h14, {20'h0, CAL_VAL});
        wr(8'h00, 32'h1_0000);
        repeat (2) @(posedge clk);
        chk32("calrun", 32'h1, {31'h0, ana.cal_run});
        repeat (sar_seq_pkg::CAL_CYCLES + 6) @(posedge clk);
        rd(8'h04, 32'h4);
        finish_test();
    end
endmodule
